// >>> logic/tmac_pkg.sv
/*
  Shared constants, types and helpers of the temperature monitor alert control.
  Assumes a 100 MHz system clock and a front end that delivers 11-bit results.
*/
package tmac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and channel layout
  localparam int unsigned TEMP_W    = 11;
  localparam int unsigned NEED_W    = 3;
  localparam int unsigned CNT_W     = 4;
  localparam int unsigned RATE_W    = 4;
  localparam int unsigned NUM_CH    = 2;
  localparam int unsigned CH_INT    = 0;
  localparam int unsigned CH_EXT    = 1;
  localparam int unsigned MSB_LO    = 3;                  // Result bits in the low byte
  localparam int unsigned LSB_GAP   = 5;                  // Zero bits under the low byte
  localparam int unsigned SYNC_W    = TEMP_W + 3;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion rate codes: 0 is one per 16 s, each step doubles the rate
  localparam logic [RATE_W-1:0] RATE_2PS     = 4'h5;
  localparam logic [RATE_W-1:0] RATE_4PS     = 4'h6;      // Reset value
  localparam logic [RATE_W-1:0] RATE_8PS     = 4'h7;
  localparam logic [RATE_W-1:0] RATE_16PS    = 4'h8;
  localparam logic [RATE_W-1:0] RATE_32PS    = 4'h9;
  localparam logic [RATE_W-1:0] RATE_64PS    = 4'hA;
  localparam logic [RATE_W-1:0] RATE_DEFAULT = RATE_4PS;

  // Timing: slowest conversion period in seconds, clock rate in hertz
  localparam int unsigned CONV_BASE_S  = 16;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BASE_CYC     = CONV_BASE_S * CLK_HZ;

  ////////////////////////////////////////////////////////////////////////////
  // Measurement length factor handed to the front end
  typedef enum logic [2:0] {
    AVG_HALF = 3'b000,
    AVG_X1   = 3'b001,
    AVG_X2   = 3'b010,
    AVG_X4   = 3'b011,
    AVG_X8   = 3'b100,
    AVG_X16  = 3'b101
  } tmac_avg_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INT  = 2'b01,
    ST_EXT  = 2'b10
  } tmac_state_e;

  // Factor for a rate; averaging off keeps single length except at the top rate
  function automatic tmac_avg_e avg_factor(input logic [RATE_W-1:0] rate, input logic dis);
    tmac_avg_e f;
    f = AVG_X1;
    if (rate >= RATE_64PS) begin
      f = AVG_HALF;
    end else if (dis) begin
      f = AVG_X1;
    end else if (rate <= RATE_2PS) begin
      f = AVG_X16;
    end else begin
      unique case (rate)
        RATE_4PS:  f = AVG_X8;
        RATE_8PS:  f = AVG_X4;
        RATE_16PS: f = AVG_X2;
        default:   f = AVG_X1;
      endcase
    end
    return f;
  endfunction : avg_factor

  // Limit minus hysteresis, stopping at zero
  function automatic logic [TEMP_W-1:0] sub_sat(input logic [TEMP_W-1:0] a,
                                                input logic [TEMP_W-1:0] b);
    return (a > b) ? (a - b) : '0;
  endfunction : sub_sat

  // Consecutive counter step: count while the condition holds, saturating
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c, input logic hit);
    logic [CNT_W-1:0] n;
    n = '0;
    if (hit) begin
      n = (c == '1) ? c : c + 1'b1;
    end
    return n;
  endfunction : cnt_step

endpackage : tmac_pkg

// >>> logic/tmac_chan_if.sv
/*
  Bundle between the sequencer and one channel's limit checker.
  Assumes the sequencer drives settings and a one-cycle measurement strobe.
*/
`timescale 1ns/1ns
interface tmac_chan_if;
  logic                          meas_valid;
  logic [tmac_pkg::TEMP_W-1:0]   result;
  logic                          fault;
  logic [tmac_pkg::TEMP_W-1:0]   high_lim;
  logic [tmac_pkg::TEMP_W-1:0]   low_lim;
  logic [tmac_pkg::TEMP_W-1:0]   crit_lim;
  logic [tmac_pkg::TEMP_W-1:0]   hyst;
  logic [tmac_pkg::NEED_W-1:0]   alert_need;
  logic [tmac_pkg::NEED_W-1:0]   crit_need;
  logic                          alert_hit;
  logic                          high_hit;
  logic                          high_below;
  logic                          crit_hit;
  logic                          crit_below;
  logic                          cause_high;
  logic                          cause_low;
  logic                          cause_fault;

  modport seq (output meas_valid, result, fault, high_lim, low_lim, crit_lim, hyst,
               alert_need, crit_need,
               input  alert_hit, high_hit, high_below, crit_hit, crit_below,
               cause_high, cause_low, cause_fault);
  modport chan (input  meas_valid, result, fault, high_lim, low_lim, crit_lim, hyst,
                alert_need, crit_need,
                output alert_hit, high_hit, high_below, crit_hit, crit_below,
                cause_high, cause_low, cause_fault);
endinterface : tmac_chan_if

// >>> logic/tmac_chan.sv
/*
  Limit checker of one channel with its consecutive-event counters.
  Assumes a one-cycle measurement strobe with result and fault held beside it.
*/
`timescale 1ns/1ns
module tmac_chan (
  input  wire logic     clock_i,
  input  wire logic     reset_i,
  tmac_chan_if.chan     ch
);

  logic [tmac_pkg::CNT_W-1:0] acnt_q;
  logic [tmac_pkg::CNT_W-1:0] hcnt_q;
  logic [tmac_pkg::CNT_W-1:0] ccnt_q;
  logic                       over_high;
  logic                       under_low;
  logic                       over_crit;
  logic                       out_lim;

  ////////////////////////////////////////////////////////////////////////////
  // Raw comparisons; a faulted result skips the low and critical checks
  assign over_high = ch.result > ch.high_lim;
  assign under_low = !ch.fault && (ch.result < ch.low_lim);
  assign over_crit = !ch.fault && (ch.result >= ch.crit_lim);
  assign out_lim   = ch.fault || over_high || under_low;

  // Counters only move on a finished measurement
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      acnt_q <= '0;
      hcnt_q <= '0;
      ccnt_q <= '0;
    end else if (ch.meas_valid) begin
      acnt_q <= tmac_pkg::cnt_step(acnt_q, out_lim);
      hcnt_q <= tmac_pkg::cnt_step(hcnt_q, over_high);
      ccnt_q <= tmac_pkg::cnt_step(ccnt_q, over_crit);
    end
  end

  // Hit once the count passes the programmed need; need 0 means one event
  assign ch.alert_hit = acnt_q > {1'b0, ch.alert_need};
  assign ch.high_hit  = hcnt_q > {1'b0, ch.alert_need};
  assign ch.crit_hit  = ccnt_q > {1'b0, ch.crit_need};

  // Release levels and causes, held until the next measurement
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ch.high_below  <= 1'b1;
      ch.crit_below  <= 1'b1;
      ch.cause_high  <= 1'b0;
      ch.cause_low   <= 1'b0;
      ch.cause_fault <= 1'b0;
    end else if (ch.meas_valid) begin
      ch.high_below  <= ch.result < tmac_pkg::sub_sat(ch.high_lim, ch.hyst);
      ch.crit_below  <= ch.result < tmac_pkg::sub_sat(ch.crit_lim, ch.hyst);
      ch.cause_high  <= over_high;
      ch.cause_low   <= under_low;
      ch.cause_fault <= ch.fault;
    end
  end

endmodule : tmac_chan

// >>> logic/tmac_top.sv
/*
  Conversion sequencer, result store, status flags and alarm outputs of a
  two-channel temperature monitor. Assumes an analog front end that answers a
  conversion request by one rising edge of its own link clock with data and
  fault stable around it, and a host that drives the settings ports.
*/

`timescale 1ns/1ns
module tmac_top #(
  parameter int unsigned BASE_PERIOD_CYC = tmac_pkg::BASE_CYC
) (
  input  wire logic                                   clock_i,
  input  wire logic                                   reset_i,
  input  wire logic                                   run_i,
  input  wire logic                                   one_shot_i,
  input  wire logic [tmac_pkg::RATE_W-1:0]            rate_i,
  input  wire logic                                   rate_we_i,
  input  wire logic                                   avg_dis_i,
  input  wire logic                                   comp_mode_i,
  input  wire logic                                   mask_all_i,
  input  wire logic [tmac_pkg::NUM_CH-1:0]            chan_mask_i,
  input  wire logic [tmac_pkg::NUM_CH-1:0][10:0]      high_lim_i,
  input  wire logic [tmac_pkg::NUM_CH-1:0][10:0]      low_lim_i,
  input  wire logic [tmac_pkg::NUM_CH-1:0][10:0]      crit_lim_i,
  input  wire logic [tmac_pkg::TEMP_W-1:0]            hyst_i,
  input  wire logic [tmac_pkg::NEED_W-1:0]            alert_need_i,
  input  wire logic [tmac_pkg::NEED_W-1:0]            crit_need_i,
  input  wire logic                                   status_clr_i,
  input  wire logic                                   fe_clk_i,
  input  wire logic [tmac_pkg::TEMP_W-1:0]            fe_data_i,
  input  wire logic                                   fe_fault_i,
  input  wire logic                                   fe_beta_i,
  output logic                                        conv_req_o,
  output logic                                        conv_chan_o,
  output logic [2:0]                                  conv_avg_o,
  output logic [tmac_pkg::RATE_W-1:0]                 rate_o,
  output logic                                        busy_o,
  output logic [tmac_pkg::NUM_CH-1:0][7:0]            temp_msb_o,
  output logic [tmac_pkg::NUM_CH-1:0][7:0]            temp_lsb_o,
  output logic [tmac_pkg::NUM_CH-1:0]                 status_high_o,
  output logic [tmac_pkg::NUM_CH-1:0]                 status_low_o,
  output logic [tmac_pkg::NUM_CH-1:0]                 status_fault_o,
  output logic [tmac_pkg::NUM_CH-1:0]                 status_crit_o,
  output logic                                        beta_sel_o,
  output logic                                        alert_o,
  output logic                                        alert_oe_o,
  output logic                                        therm_o,
  output logic                                        therm_oe_o
);

  localparam int unsigned NC = tmac_pkg::NUM_CH;

  tmac_pkg::tmac_state_e             state_q;
  logic [tmac_pkg::RATE_W-1:0]       rate_q;
  logic [31:0]                       timer_q;
  logic                              tick_pend_q;
  logic                              one_shot_q;
  logic [tmac_pkg::SYNC_W-1:0]       sync1_q;
  logic [tmac_pkg::SYNC_W-1:0]       sync2_q;
  logic                              fe_clk_prev_q;
  logic                              fe_edge;
  logic [tmac_pkg::TEMP_W-1:0]       fe_data;
  logic                              fe_fault;
  logic                              fe_beta;
  logic [NC-1:0]                     meas_valid;
  logic [NC-1:0][10:0]               result_q;
  logic [NC-1:0]                     alert_hit;
  logic [NC-1:0]                     high_hit;
  logic [NC-1:0]                     high_below;
  logic [NC-1:0]                     crit_hit;
  logic [NC-1:0]                     crit_below;
  logic [NC-1:0]                     cause_high;
  logic [NC-1:0]                     cause_low;
  logic [NC-1:0]                     cause_fault;
  logic                              therm_q;
  logic                              therm_d;
  logic                              comp_q;
  logic                              comp_d;
  logic [NC-1:0]                     high_flag_q;
  logic [NC-1:0]                     low_flag_q;
  logic [NC-1:0]                     fault_flag_q;
  logic [NC-1:0]                     crit_flag_q;
  logic                              alert_oe_q;
  logic                              alert_d;
  logic [31:0]                       period_cyc;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion rate setting, reset to four per second
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rate_q <= tmac_pkg::RATE_DEFAULT;
    end else if (rate_we_i) begin
      rate_q <= (rate_i > tmac_pkg::RATE_64PS) ? tmac_pkg::RATE_64PS : rate_i;
    end
  end
  assign rate_o = rate_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link inputs: two flops before any use, then rising-edge detect
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1_q       <= '0;
      sync2_q       <= '0;
      fe_clk_prev_q <= 1'b0;
    end else begin
      sync1_q       <= {fe_clk_i, fe_fault_i, fe_beta_i, fe_data_i};
      sync2_q       <= sync1_q;
      fe_clk_prev_q <= sync2_q[tmac_pkg::SYNC_W-1];
    end
  end
  assign fe_edge  = sync2_q[tmac_pkg::SYNC_W-1] && !fe_clk_prev_q;
  assign fe_fault = sync2_q[tmac_pkg::TEMP_W+1];
  assign fe_beta  = sync2_q[tmac_pkg::TEMP_W];
  assign fe_data  = sync2_q[tmac_pkg::TEMP_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Period timer; it only runs in active mode so standby starts nothing
  assign period_cyc = BASE_PERIOD_CYC >> rate_q;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      timer_q     <= '0;
      tick_pend_q <= 1'b0;
    end else if (!run_i) begin
      timer_q     <= '0;
      tick_pend_q <= 1'b0;
    end else if (timer_q == '0) begin
      timer_q     <= period_cyc - 1'b1;
      tick_pend_q <= 1'b1;
    end else begin
      timer_q     <= timer_q - 1'b1;
      if (state_q == tmac_pkg::ST_IDLE) begin
        tick_pend_q <= 1'b0;
      end
    end
  end

  // Sequencer: internal channel then external, one answer edge each.
  // A slow front end stretches the pass; a missed period is not queued twice.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q    <= tmac_pkg::ST_IDLE;
      one_shot_q <= 1'b0;
    end else begin
      unique case (state_q)
        tmac_pkg::ST_IDLE: begin
          if (run_i && tick_pend_q) begin
            state_q    <= tmac_pkg::ST_INT;
            one_shot_q <= 1'b0;
          end else if (!run_i && one_shot_i) begin
            state_q    <= tmac_pkg::ST_INT;
            one_shot_q <= 1'b1;
          end
        end
        tmac_pkg::ST_INT: begin
          if (fe_edge) begin
            state_q <= tmac_pkg::ST_EXT;
          end
        end
        tmac_pkg::ST_EXT: begin
          if (fe_edge) begin
            state_q    <= tmac_pkg::ST_IDLE;
            one_shot_q <= 1'b0;
          end
        end
      endcase
    end
  end
  // One-shot while active never reaches the sequencer above

  // Request to the front end; averaging applies to the external channel only
  assign conv_req_o  = state_q != tmac_pkg::ST_IDLE;
  assign conv_chan_o = state_q == tmac_pkg::ST_EXT;
  assign conv_avg_o  = (state_q == tmac_pkg::ST_EXT)
                     ? tmac_pkg::avg_factor(rate_q, avg_dis_i)
                     : tmac_pkg::AVG_X1;
  assign busy_o      = conv_req_o;

  // A measurement counts only inside a pass, so link edges between passes leave data alone
  assign meas_valid[tmac_pkg::CH_INT] = fe_edge && (state_q == tmac_pkg::ST_INT);
  assign meas_valid[tmac_pkg::CH_EXT] = fe_edge && (state_q == tmac_pkg::ST_EXT);

  ////////////////////////////////////////////////////////////////////////////
  // Result store and beta choice from the detected diode type
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      result_q   <= '0;
      beta_sel_o <= 1'b0;
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (meas_valid[i]) begin
          result_q[i] <= fe_fault ? '0 : fe_data;
        end
      end
      if (meas_valid[tmac_pkg::CH_EXT] && !fe_fault) begin
        beta_sel_o <= fe_beta;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel checkers
  tmac_chan_if ch_if [NC] ();

  generate
    for (genvar g = 0; g < NC; g++) begin : g_chan
      assign ch_if[g].meas_valid = meas_valid[g];
      assign ch_if[g].result     = fe_fault ? '0 : fe_data;
      assign ch_if[g].fault      = fe_fault && (g == tmac_pkg::CH_EXT);
      assign ch_if[g].high_lim   = high_lim_i[g];
      assign ch_if[g].low_lim    = low_lim_i[g];
      assign ch_if[g].crit_lim   = crit_lim_i[g];
      assign ch_if[g].hyst       = hyst_i;
      assign ch_if[g].alert_need = alert_need_i;
      assign ch_if[g].crit_need  = crit_need_i;
      assign alert_hit[g]        = ch_if[g].alert_hit;
      assign high_hit[g]         = ch_if[g].high_hit;
      assign high_below[g]       = ch_if[g].high_below;
      assign crit_hit[g]         = ch_if[g].crit_hit;
      assign crit_below[g]       = ch_if[g].crit_below;
      assign cause_high[g]       = ch_if[g].cause_high;
      assign cause_low[g]        = ch_if[g].cause_low;
      assign cause_fault[g]      = ch_if[g].cause_fault;

      tmac_chan u_chan (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .ch      (ch_if[g])
      );

      // Result split: eight upper bits high, three lower bits atop the low byte
      assign temp_msb_o[g] = result_q[g][tmac_pkg::TEMP_W-1:tmac_pkg::MSB_LO];
      assign temp_lsb_o[g] = {result_q[g][tmac_pkg::MSB_LO-1:0],
                              {tmac_pkg::LSB_GAP{1'b0}}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Over-temperature: no mask reaches it; releases only when all are clear
  assign therm_d = therm_q ? !(&crit_below) : (|crit_hit);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      therm_q <= 1'b0;
    end else begin
      therm_q <= therm_d;
    end
  end

  // Critical flags ride with the output; reads cannot clear them
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      crit_flag_q <= '0;
    end else if (therm_d) begin
      crit_flag_q <= crit_flag_q | crit_hit;
    end else begin
      crit_flag_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator latch: unmasked high hit sets, all below high minus hyst clears
  assign comp_d = comp_q ? !(&high_below) : (|(high_hit & ~chan_mask_i));

  always_ff @(posedge clock_i) begin
    if (reset_i || !comp_mode_i) begin
      comp_q <= 1'b0;
    end else begin
      comp_q <= comp_d;
    end
  end

  // Status flags. Interrupt mode: sticky, host clear loses to a new event.
  // Comparator mode: high flags follow the latch and ignore the clear.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      high_flag_q  <= '0;
      low_flag_q   <= '0;
      fault_flag_q <= '0;
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (comp_mode_i) begin
          high_flag_q[i] <= comp_d && (high_flag_q[i] || high_hit[i]);
        end else begin
          high_flag_q[i] <= (alert_hit[i] && cause_high[i])
                         || (high_flag_q[i] && !status_clr_i);
        end
        low_flag_q[i]   <= (alert_hit[i] && cause_low[i])
                        || (low_flag_q[i] && !status_clr_i);
        fault_flag_q[i] <= (alert_hit[i] && cause_fault[i])
                        || (fault_flag_q[i] && !status_clr_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert pin drive. Interrupt: any unmasked flag, global mask releases it.
  // Comparator: latch only, global mask has no say.
  always_comb begin
    if (comp_mode_i) begin
      alert_d = comp_q;
    end else begin
      alert_d = !mask_all_i
             && (|((high_flag_q | low_flag_q | fault_flag_q) & ~chan_mask_i));
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      alert_oe_q <= 1'b0;
    end else begin
      alert_oe_q <= alert_d;
    end
  end

  // Open-drain pins: data always low, only the enable moves
  assign alert_o    = 1'b0;
  assign alert_oe_o = alert_oe_q;
  assign therm_o    = 1'b0;
  assign therm_oe_o = therm_q;

  assign status_high_o  = high_flag_q;
  assign status_low_o   = low_flag_q;
  assign status_fault_o = fault_flag_q;
  assign status_crit_o  = crit_flag_q;

endmodule : tmac_top

// >>> tb/tmac_top_chk.sv
/* Port assertions of the monitor top.
   Assumes it is bound onto tmac_top. */
`timescale 1ns/1ns
module tmac_top_chk (
  input wire logic clock_i, reset_i, run_i, one_shot_i, avg_dis_i, mask_all_i, comp_mode_i,
  input wire logic conv_req_o, conv_chan_o, alert_o, alert_oe_o, therm_o, therm_oe_o,
  input wire logic [2:0] conv_avg_o,
  input wire logic [tmac_pkg::RATE_W-1:0] rate_o,
  input wire logic [tmac_pkg::NUM_CH-1:0][7:0] temp_msb_o,
  input wire logic [tmac_pkg::NUM_CH-1:0] status_crit_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  // Shared lines may only be pulled low
  a_pins_low: assert property (!alert_o && !therm_o)
    else $error("alarm pin driven high");
  a_rate_reset: assert property ($fell(reset_i) |-> rate_o == 4'h6)
    else $error("rate after reset");
  a_oneshot_go: assert property (!run_i && !conv_req_o && one_shot_i
      |=> conv_req_o && !conv_chan_o)
    else $error("one-shot pass missing");
  a_avg_rate4: assert property (conv_req_o && conv_chan_o && !avg_dis_i
      && rate_o == 4'h6 |-> conv_avg_o == 3'h4)
    else $error("factor at four per second");
  a_avg_off: assert property (conv_req_o && conv_chan_o && avg_dis_i
      && rate_o != 4'hA |-> conv_avg_o == 3'h1)
    else $error("factor with averaging off");
  a_avg_top: assert property (conv_req_o && conv_chan_o && rate_o == 4'hA
      |-> conv_avg_o == 3'h0)
    else $error("factor at top rate");
  a_crit_flags: assert property ((|status_crit_o) == therm_oe_o)
    else $error("crit flags apart from therm");
  a_mask_quiet: assert property (!comp_mode_i && mask_all_i
      ##1 !comp_mode_i && mask_all_i |-> !alert_oe_o)
    else $error("masked alert pulled");
  a_idle_hold: assert property (!conv_req_o |=> $stable(temp_msb_o))
    else $error("result moved while idle");
  c_therm: cover property ($rose(therm_oe_o));
  c_alert: cover property ($rose(alert_oe_o));
  c_oneshot: cover property ($rose(conv_req_o) && !run_i);
endmodule : tmac_top_chk
bind tmac_top tmac_top_chk u_chk (.*);

// >>> tb/tmac_fe_model.sv
/* Front-end model: one link clock pulse answers each channel request.
   Assumes the request and channel select are levels. */
`timescale 1ns/1ns
module tmac_fe_model (
  input  wire logic clock_i, req_i, chan_i, fault_i,
  input  wire logic [1:0][10:0] temp_i,
  output logic fe_clk_o, fault_o, beta_o,
  output logic [10:0] data_o
);
  initial {fe_clk_o, fault_o, beta_o, data_o} = '0;
  ////////////////////////////////////////
  // Link clock rests low between frames; stale data is scrambled
  always begin
    @(posedge clock_i);
    #1;
    if (req_i) begin
      data_o = temp_i[chan_i];
      fault_o = fault_i && chan_i;
      beta_o = temp_i[1][0];
      #83 fe_clk_o = 1'b1;
      #80 fe_clk_o = 1'b0;
      data_o = ~data_o;
      fault_o = ~fault_o;
    end
  end
endmodule : tmac_fe_model

// >>> tb/testbench.sv
/* Self-checking bench of the monitor top with a front-end model.
   Assumes the design and checker are compiled first. */
`timescale 1ns/1ns
module testbench;
  logic clock_i = 0, reset_i = 1, run_i = 0, one_shot_i = 0, rate_we_i = 0, avg_dis_i = 0;
  logic mask_all_i = 0, status_clr_i = 0, fault_i = 0, fe_clk_i, fe_fault_i, fe_beta_i;
  logic conv_req_o, conv_chan_o, busy_o, beta_sel_o, alert_o, alert_oe_o, therm_o, therm_oe_o;
  logic [2:0] conv_avg_o;
  logic [3:0] rate_i = 4'hA, rate_o;
  logic [1:0][7:0] temp_msb_o, temp_lsb_o;
  logic [1:0] status_high_o, status_low_o, status_fault_o, status_crit_o;
  logic [1:0] chan_mask_i = 2'h0;
  logic comp_mode_i = 0;
  logic [1:0][10:0] temp_i = '0, high_lim_i = {2{11'h400}}, low_lim_i = {2{11'h010}};
  logic [1:0][10:0] crit_lim_i = {2{11'h600}};
  logic [10:0] fe_data_i, r;
  logic [31:0] lfsr = 32'hef9e_acec, note_q[$];
  int bad_count = 0, tests_run = 0;
  tmac_top #(.BASE_PERIOD_CYC(2048)) dut (.*, .hyst_i(11'h040), .alert_need_i(3'h0),
    .crit_need_i(3'h0));
  tmac_fe_model u_fe (.clock_i, .req_i(conv_req_o), .chan_i(conv_chan_o), .fault_i, .temp_i,
    .fe_clk_o(fe_clk_i), .fault_o(fe_fault_i), .beta_o(fe_beta_i), .data_o(fe_data_i));
  always #5 clock_i = ~clock_i;
  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic close_out();
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // Random source for the internal channel
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // One pass: standby one-shot, or a spell of active mode; fault zeroes the result
  task automatic pass(input logic [10:0] t1, input logic f, act);
    lfsr = lfsr_next(lfsr);
    temp_i = {t1, 11'h100 | lfsr[7:0]};
    fault_i = f;
    r = f ? 11'h000 : t1;
    repeat (act ? 2 : 1) note_q.push_back({r, 5'h00, temp_i[0], 5'h00}); // Two passes per spell
    {run_i, one_shot_i} = {act, !act};
    repeat (act ? 60 : 1) @(posedge clock_i);
    #1 {run_i, one_shot_i} = 2'b00;
    repeat (300) if (busy_o) @(posedge clock_i);
    repeat (4) @(posedge clock_i);
    #1;
    cmp(busy_o, 1'b0);
  endtask : pass
  // The oldest note is checked as each pass ends
  always @(negedge busy_o) begin
    #2;
    if (note_q.size() > 0)
      cmp({temp_msb_o[1], temp_lsb_o[1], temp_msb_o[0], temp_lsb_o[0]}, note_q.pop_front());
  end
  initial begin
    repeat (5) @(posedge clock_i);
    #1 reset_i = 0;
    cmp(rate_o, 4'h6);
    pass(11'h200, 0, 0);
    pass(11'h650, 0, 0);
    cmp({therm_oe_o, status_crit_o, alert_oe_o}, 4'b1101);
    pass(11'h200, 0, 0);
    cmp({therm_oe_o, status_crit_o, alert_oe_o}, 4'b0001);
    mask_all_i = 1;
    repeat (2) @(posedge clock_i);
    #1 cmp(alert_oe_o, 1'b0);
    {mask_all_i, status_clr_i} = 2'b01;
    @(posedge clock_i);
    #1 status_clr_i = 0;
    repeat (3) @(posedge clock_i);
    #1 cmp(alert_oe_o, 1'b0);
    avg_dis_i = 1;
    pass(11'h300, 1, 0);
    cmp({status_fault_o[1], status_low_o[1], alert_oe_o}, 3'b101);
    {avg_dis_i, rate_we_i} = 2'b01;
    @(posedge clock_i);
    #1 rate_we_i = 0;
    pass(11'h281, 0, 1);
    cmp(rate_o, 4'hA);
    cmp(beta_sel_o, 1'b1);
    // Comparator mode: channel mask, global mask ignored, hysteresis release
    {comp_mode_i, mask_all_i, chan_mask_i} = 4'b1110;
    pass(11'h450, 0, 0);
    cmp({status_high_o[1], alert_oe_o}, 2'b00);
    chan_mask_i = 2'h0;
    pass(11'h450, 0, 0);
    cmp({status_high_o[1], alert_oe_o}, 2'b11);
    status_clr_i = 1;
    pass(11'h3f0, 0, 0);
    cmp({status_high_o[1], alert_oe_o}, 2'b11);
    status_clr_i = 0;
    pass(11'h200, 0, 0);
    cmp({status_high_o[1], alert_oe_o}, 2'b00);
    cmp(note_q.size(), 0);
    close_out();
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule : testbench
